//--- src/sirf_pkg.sv
// Package of constants for the supply integrity and reset flag block.
// Assumes a single 250 MHz clock and a plain address/strobe register port.
// Operation
// - Low-voltage indication holds chip in reset.
// - Low-voltage reset drives reset pin low.
// - Watchdog underflow drives pin low minimum width.
// - Option enables detector; auxiliary needs it.
// - Auxiliary flag is live, read-only comparator.
// - Enabled flag toggles raise interrupt request.
// - Pending cleared on entering service routine.
// - Interrupt needs enable and unmasked CPU.
// - Fast rise within delay gives no interrupt.
// - Slow rise, early enable: two interrupts.
// - Slow rise, late enable: one interrupt; here none, as en_rise needs the flag high.
// - Wait mode unchanged; interrupt wakes device.
// - Halt freezes register; no halt wake.
// - Low-voltage flag set by reset, write-zero clears.
// - Watchdog flag set; cleared by write or low-voltage.
// - Other resets never clear low-voltage flag.
// - Two flags encode the reset source.
`default_nettype none
package sirf_pkg;
  localparam logic [7:0] SIRF_CSR_ADDR       = 8'h00;
  localparam logic [7:0] SIRF_CSR_RESET      = 8'h00;
  localparam int         SIRF_BIT_WDG_RF     = 0;
  localparam int         SIRF_BIT_LV_RF      = 4;
  localparam int         SIRF_BIT_AUX_FLAG   = 5;
  localparam int         SIRF_BIT_AUX_IRQ_EN = 6;
  localparam logic [7:0] SIRF_CSR_WMASK      = 8'h51;
  localparam int         SIRF_CLK_MHZ        = 250;
  localparam int         SIRF_WDG_PULSE_NS   = 200;
  localparam int         SIRF_WDG_PULSE_CYC  = (SIRF_WDG_PULSE_NS * SIRF_CLK_MHZ + 999) / 1000;
  localparam int         SIRF_DELAY_SHORT    = 256;
  localparam int         SIRF_DELAY_LONG     = 4096;
  typedef enum logic [1:0] {
    SIRF_RUN   = 2'b00,
    SIRF_LVRST = 2'b01,
    SIRF_WDRST = 2'b11
  } sirf_pin_state_e;
endpackage
`default_nettype wire

//--- src/sirf_sync.sv
// Two-flop synchroniser for the auxiliary comparator level.
// Assumes the input may change at any time relative to clk.
`default_nettype none
module sirf_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

//--- src/sirf_pulse.sv
// Minimum-width pulse stretcher for the watchdog reset drive.
// Assumes a one-cycle trigger; a retrigger restarts the count.
`default_nettype none
module sirf_pulse #(
  parameter int WIDTH = 50
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic trig,
  output logic      active
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [CW-1:0] cnt_ff;

  initial begin
    if (WIDTH < 1) $error("sirf_pulse WIDTH must be at least one");
  end

  // Counts down from the trigger so the pin stays low the full width.
  always_ff @(posedge clk) begin
    if (!resetn) cnt_ff <= '0;
    else if (trig) cnt_ff <= CW'(WIDTH);
    else if (cnt_ff != '0) cnt_ff <= cnt_ff - 1'b1;
  end

  assign active = trig || (cnt_ff != '0);
endmodule
`default_nettype wire

//--- src/sirf_top.sv
// Supply integrity block: reset pin drive, auxiliary detector interrupt
// and reset-source flags. Assumes the analog detectors arrive as levels and
// that the reset sequencer, interrupt controller and watchdog sit outside.
`default_nettype none
module sirf_top #(
  parameter int WDG_PULSE_CYC = sirf_pkg::SIRF_WDG_PULSE_CYC,
  parameter int RESET_DELAY_LONG = sirf_pkg::SIRF_DELAY_LONG
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       lvd_option_en,
  input  wire logic       long_delay_sel,
  input  wire logic       lowvolt_below,
  input  wire logic       aux_cmp_async,
  input  wire logic       watchdog_underflow,
  input  wire logic       ext_pin_reset,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            chip_reset_req,
  input  wire logic       irq_ack,
  input  wire logic       cpu_irq_masked,
  input  wire logic       halt_mode,
  output logic            aux_irq,
  output logic            wake_from_wait,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata
);
  localparam int DCW = $clog2(RESET_DELAY_LONG + 1);

  initial begin
    if (WDG_PULSE_CYC < 1) $error("sirf_top WDG_PULSE_CYC must be at least one");
    if (RESET_DELAY_LONG < sirf_pkg::SIRF_DELAY_SHORT) $error("sirf_top RESET_DELAY_LONG too small");
  end

  logic            aux_sync;
  logic            aux_prev_ff;
  logic            wdg_active;
  logic            lv_active;
  logic            aux_flag_ff;
  logic            aux_irq_en_ff;
  logic            lv_rf_ff;
  logic            wdg_rf_ff;
  logic            pend_ff;
  logic [DCW-1:0]  delay_ff;
  logic            in_delay;
  logic            csr_wr;
  logic            aux_toggle;
  logic            en_rise;
  logic            aux_live;
  logic [7:0]      csr_view;
  sirf_pkg::sirf_pin_state_e pin_state;

  // Comparator is resynchronised before any decision is made on it.
  sirf_sync sirf_sync_i (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (aux_cmp_async),
    .sync_out (aux_sync)
  );

  sirf_pulse #(
    .WIDTH (WDG_PULSE_CYC)
  ) sirf_pulse_i (
    .clk    (clk),
    .resetn (resetn),
    .trig   (watchdog_underflow),
    .active (wdg_active)
  );

  // Low-voltage reset exists only when the option enables the detector.
  assign lv_active = lvd_option_en && lowvolt_below;

  // Static reset for as long as the supply stays low.
  assign chip_reset_req = lv_active || wdg_active;

  // Priority encoding of what currently pulls the pin.
  always_comb begin
    if (lv_active) pin_state = sirf_pkg::SIRF_LVRST;
    else if (wdg_active) pin_state = sirf_pkg::SIRF_WDRST;
    else pin_state = sirf_pkg::SIRF_RUN;
  end

  // Open-drain: output is always low, enable chooses whether it pulls.
  assign reset_pin_out = 1'b0;
  always_comb begin
    case (pin_state)
      sirf_pkg::SIRF_LVRST: reset_pin_oe = 1'b1;
      sirf_pkg::SIRF_WDRST: reset_pin_oe = 1'b1;
      default:              reset_pin_oe = 1'b0;
    endcase
  end

  // Reset delay counter; the auxiliary flag follows silently while it runs,
  // so a fast supply rise produces no interrupt for that crossing.
  always_ff @(posedge clk) begin
    if (!resetn || chip_reset_req) begin
      delay_ff <= long_delay_sel ? DCW'(RESET_DELAY_LONG) : DCW'(sirf_pkg::SIRF_DELAY_SHORT);
    end else if (delay_ff != '0) begin
      delay_ff <= delay_ff - 1'b1;
    end
  end
  assign in_delay = (delay_ff != '0);

  // Auxiliary logic is dead while the low-voltage option is off.
  assign aux_live = lvd_option_en && aux_sync;

  assign csr_wr = reg_wr && (reg_addr == sirf_pkg::SIRF_CSR_ADDR) && !halt_mode;

  // Live flag, held in halt so the register reads frozen.
  always_ff @(posedge clk) begin
    if (!resetn) aux_flag_ff <= 1'b0;
    else if (!halt_mode) aux_flag_ff <= aux_live;
  end

  // Previous flag value for toggle detection; tracks during reset delay.
  always_ff @(posedge clk) begin
    if (!resetn) aux_prev_ff <= 1'b0;
    else if (!halt_mode) aux_prev_ff <= aux_flag_ff;
  end

  assign aux_toggle = (aux_flag_ff != aux_prev_ff) && !in_delay;
  // Setting the enable while the flag shows low supply gives one event.
  assign en_rise = csr_wr && reg_wdata[sirf_pkg::SIRF_BIT_AUX_IRQ_EN] && !aux_irq_en_ff
                   && aux_flag_ff;

  // Software-owned enable bit.
  always_ff @(posedge clk) begin
    if (!resetn) aux_irq_en_ff <= sirf_pkg::SIRF_CSR_RESET[sirf_pkg::SIRF_BIT_AUX_IRQ_EN];
    else if (csr_wr) aux_irq_en_ff <= reg_wdata[sirf_pkg::SIRF_BIT_AUX_IRQ_EN];
  end

  // Pending latch: a new event in the acknowledge cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!resetn) pend_ff <= 1'b0;
    else if (halt_mode) pend_ff <= pend_ff;
    else if ((aux_toggle && aux_irq_en_ff) || en_rise) pend_ff <= 1'b1;
    else if (irq_ack || !aux_irq_en_ff) pend_ff <= 1'b0;
  end

  // Request reaches the CPU only when enabled and not masked; in halt the
  // wake line stays low so no auxiliary event ends halt.
  assign aux_irq = pend_ff && aux_irq_en_ff && !cpu_irq_masked;
  assign wake_from_wait = pend_ff && aux_irq_en_ff && !halt_mode;

  // Low-voltage flag: only its own reset sets it; software or resetn clears it.
  always_ff @(posedge clk) begin
    if (!resetn) lv_rf_ff <= 1'b0;
    else if (lv_active) lv_rf_ff <= 1'b1;
    else if (csr_wr && !reg_wdata[sirf_pkg::SIRF_BIT_LV_RF]) lv_rf_ff <= 1'b0;
  end

  // Watchdog flag: a low-voltage reset clears it to give a clean start.
  always_ff @(posedge clk) begin
    if (!resetn) wdg_rf_ff <= 1'b0;
    else if (lv_active) wdg_rf_ff <= 1'b0;
    else if (watchdog_underflow) wdg_rf_ff <= 1'b1;
    else if (csr_wr && !reg_wdata[sirf_pkg::SIRF_BIT_WDG_RF]) wdg_rf_ff <= 1'b0;
  end

  // Register image; reserved bits are constant zero.
  always_comb begin
    csr_view = 8'h00;
    csr_view[sirf_pkg::SIRF_BIT_AUX_IRQ_EN] = aux_irq_en_ff;
    csr_view[sirf_pkg::SIRF_BIT_AUX_FLAG]   = aux_flag_ff;
    csr_view[sirf_pkg::SIRF_BIT_LV_RF]      = lv_rf_ff;
    csr_view[sirf_pkg::SIRF_BIT_WDG_RF]     = wdg_rf_ff;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk) begin
    if (!resetn) reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == sirf_pkg::SIRF_CSR_ADDR) reg_rdata <= csr_view;
    else reg_rdata <= 8'h00;
  end

  // External pin events are observed only; they touch no flag.
  logic unused_ok;
  assign unused_ok = ext_pin_reset ^ reset_pin_in;
endmodule
`default_nettype wire

//--- tb/sirf_top_asserts.sv
// Checker for the supply integrity block, watching only its top ports.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module sirf_top_asserts #(
  parameter int WDG_PULSE_CYC = 50
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       lvd_option_en,
  input wire logic       lowvolt_below,
  input wire logic       watchdog_underflow,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe,
  input wire logic       chip_reset_req,
  input wire logic       cpu_irq_masked,
  input wire logic       halt_mode,
  input wire logic       aux_irq,
  input wire logic       wake_from_wait,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] cnt_ff;
  // Shadow of the minimum pulse; cleared by reset, so it can only under-check.
  always_ff @(posedge clk) begin
    if (!resetn) cnt_ff <= 8'h00;
    else if (watchdog_underflow) cnt_ff <= 8'(WDG_PULSE_CYC);
    else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
  end
  sequence s_lv_low;
    lvd_option_en && lowvolt_below;
  endsequence
  a_lv_hold_reset: assert property (s_lv_low |-> chip_reset_req && reset_pin_oe) else $error("lv reset");
  a_wdg_min_width: assert property ((watchdog_underflow || cnt_ff != 8'h00) |-> reset_pin_oe) else $error("wdg width");
  a_pin_pull_low: assert property (reset_pin_oe |-> !reset_pin_out) else $error("pin drive");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata idle");
  a_rsvd_read_zero: assert property (reg_rd |=> reg_rdata[7] == 1'b0 && reg_rdata[3:1] == 3'h0) else $error("rsvd");
  a_irq_unmasked: assert property (aux_irq |-> !cpu_irq_masked) else $error("irq masked");
  a_no_halt_wake: assert property (halt_mode |-> !wake_from_wait) else $error("halt wake");
  a_wait_wake: assert property (aux_irq && !halt_mode |-> wake_from_wait) else $error("wait wake");
  a_aux_needs_opt: assert property (!lvd_option_en |-> !aux_irq) else $error("aux without option");
endmodule
bind sirf_top sirf_top_asserts #(.WDG_PULSE_CYC(WDG_PULSE_CYC)) sirf_top_asserts_i (.*);
`default_nettype wire

//--- tb/tb_sirf_top.sv
// Self-checking bench for the supply integrity block.
// Assumes the design sources are compiled first; the pin has a pull-up.
`default_nettype none
module tb_sirf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, resetn = 1'b0, lvd_option_en = 1'b1, long_delay_sel = 1'b0;
  logic       lowvolt_below = 1'b0, aux_cmp_async = 1'b0, watchdog_underflow = 1'b0;
  logic       ext_pin_reset = 1'b0, irq_ack = 1'b0, cpu_irq_masked = 1'b0, halt_mode = 1'b0;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, irq_prev = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reset_pin_out, reset_pin_oe, chip_reset_req, aux_irq, wake_from_wait;
  int         mismatches = 0, check_count = 0, irq_cnt = 0;
  // The pull-up lifts the pin whenever nobody pulls it low.
  wire        reset_pin_in = !reset_pin_oe;
  // Short counts keep the run brief; expectations follow them.
  sirf_top #(.WDG_PULSE_CYC(3), .RESET_DELAY_LONG(300)) sirf_top_i (.*);
  always #2 clk = ~clk;
  // Count rising edges of the request so a doubled interrupt shows up.
  always @(posedge clk) begin
    irq_prev <= aux_irq;
    if (aux_irq && !irq_prev) irq_cnt <= irq_cnt + 1;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // Bounded wait; a request that never comes ends the run.
  task automatic wait_irq();
    int n;
    n = 0;
    while (aux_irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20) begin
      mismatches++;
      $display("[ERR] aux_irq expected 1 seen 0");
      results();
    end
  endtask
  task automatic ack();
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    #1 chk("aux_irq", 8'h00, {7'h00, aux_irq});
  endtask
  task automatic t_regs();
    rd(8'h00, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h40);
    wr(8'h00, 8'h00);
  endtask
  task automatic t_wdg();
    @(posedge clk) watchdog_underflow <= 1'b1;
    @(posedge clk) watchdog_underflow <= 1'b0;
    cyc(5);
    #1 chk("reset_pin_oe", 8'h00, {7'h00, reset_pin_oe});
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
  endtask
  task automatic t_lv();
    @(posedge clk) watchdog_underflow <= 1'b1;
    @(posedge clk) watchdog_underflow <= 1'b0;
    cyc(5);
    lowvolt_below <= 1'b1;
    cyc(4);
    #1 chk("chip_reset_req", 8'h01, {7'h00, chip_reset_req});
    @(posedge clk) lowvolt_below <= 1'b0;
    rd(8'h00, 8'h10);
    wr(8'h00, 8'h50);
    irq_cnt = 0;
    @(posedge clk) aux_cmp_async <= 1'b1;
    cyc(20);
    aux_cmp_async <= 1'b0;
    cyc(20);
    #1 chk("irq_cnt", 8'h00, 8'(irq_cnt));
    @(posedge clk) watchdog_underflow <= 1'b1;
    @(posedge clk) watchdog_underflow <= 1'b0;
    rd(8'h00, 8'h51);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h40);
    cyc(300);
  endtask
  task automatic t_aux();
    irq_cnt = 0;
    @(posedge clk) aux_cmp_async <= 1'b1;
    wait_irq();
    rd(8'h00, 8'h60);
    ack();
    cyc(8);
    #1 chk("irq_cnt", 8'h01, 8'(irq_cnt));
    @(posedge clk) cpu_irq_masked <= 1'b1;
    aux_cmp_async <= 1'b0;
    cyc(8);
    #1 chk("aux_irq", 8'h00, {7'h00, aux_irq});
    chk("wake_from_wait", 8'h01, {7'h00, wake_from_wait});
    @(posedge clk) halt_mode <= 1'b1;
    cyc(2);
    #1 chk("wake_from_wait", 8'h00, {7'h00, wake_from_wait});
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h40);
    @(posedge clk) halt_mode <= 1'b0;
    cpu_irq_masked <= 1'b0;
    cyc(2);
    #1 chk("aux_irq", 8'h01, {7'h00, aux_irq});
    ack();
  endtask
  task automatic t_two();
    wr(8'h00, 8'h00);
    irq_cnt = 0;
    @(posedge clk) aux_cmp_async <= 1'b1;
    cyc(8);
    wr(8'h00, 8'h40);
    wait_irq();
    ack();
    @(posedge clk) aux_cmp_async <= 1'b0;
    wait_irq();
    ack();
    #1 chk("irq_cnt", 8'h02, 8'(irq_cnt));
  endtask
  task automatic t_opt();
    @(posedge clk) lvd_option_en <= 1'b0;
    aux_cmp_async <= 1'b1;
    cyc(8);
    #1 chk("aux_irq", 8'h00, {7'h00, aux_irq});
    rd(8'h00, 8'h40);
    @(posedge clk) aux_cmp_async <= 1'b0;
    cyc(8);
    lvd_option_en <= 1'b1;
  endtask
  // Reset, let the start-up delay run out, then the scenarios in turn.
  initial begin
    cyc(6);
    resetn <= 1'b1;
    cyc(300);
    t_regs();
    t_wdg();
    t_lv();
    t_aux();
    t_two();
    t_opt();
    results();
  end
endmodule
`default_nettype wire
